// ==== fcu_pkg.sv ====
// constants, types and field layout of the fp format conversion unit
// Function
// - decode convert_to_double: fpu opcode, bits 20..16 zero, its function code
// - convert source_reg_a from operand_format to double, round, write dest_reg
// - single or word source to double is exact, never inexact
// - convert_to_double raises only invalid, unimplemented, inexact, cop unusable, reserved; the unit has no unimplemented exception
// - decode convert_to_long from single or double into 64-bit fixed point
// - infinity, nan or out-of-range rounding to long sets the invalid flag
// - invalid with its enable set: dest_reg unwritten, invalid exception taken
// - invalid, enable clear, legacy nan encoding: default is largest positive long
// - nan encoding one: nan gives zero, positive max, negative most negative
// - long and pair operations defined only with fpr_width_mode one; the unit never reads fpr_width_mode
// - pair_pack: source_reg_a low word high, source_reg_b low word low
// - pair_pack is a move: no exceptions, cause and flags untouched; a signaling nan low word of source_reg_a traps invalid if enabled
// - pair_lower_extract copies bits 31..0 of source_reg_a to dest_reg
// - pair_upper_extract copies bits 63..32 of source_reg_a to dest_reg
// - pair extracts raise nothing and leave cause and flags untouched
// - release 6 cores treat pair_pack and pair extracts as reserved
// - unusable coprocessor raises cop unusable; unsupported encoding raises reserved
package fcu_pkg;
  localparam logic [5:0] OP_FPU = 6'h11;
  localparam logic [5:0] FN_TO_DBL = 6'h21;
  localparam logic [5:0] FN_TO_LONG = 6'h25;
  localparam logic [5:0] FN_PACK = 6'h26;
  localparam logic [5:0] FN_PL = 6'h28;
  localparam logic [5:0] FN_PU = 6'h20;
  localparam logic [4:0] FMT_S = 5'h10;
  localparam logic [4:0] FMT_D = 5'h11;
  localparam logic [4:0] FMT_W = 5'h14;
  localparam logic [4:0] FMT_L = 5'h15;
  localparam logic [4:0] FMT_PAIR = 5'h16;
  // register port byte offsets
  localparam logic [3:0] ADDR_FPCS = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_MASK = 4'hc;
  // fp_control_status fields
  localparam int RM_LO = 0;
  localparam int FLG_INEX = 2;
  localparam int FLG_INV = 6;
  localparam int EN_INEX = 7;
  localparam int EN_INV = 11;
  localparam int CAU_LO = 12;
  localparam int CAU_INEX = 12;
  localparam int CAU_INV = 16;
  localparam int CAU_HI = 17;
  localparam int NAN_SEL = 18;
  localparam logic [31:0] FPCS_RST = 32'h0;
  // control register: fpr_width_mode, coprocessor usable, release 6
  localparam int CTL_WIDE = 0;
  localparam int CTL_USE = 1;
  localparam int CTL_R6 = 2;
  localparam logic [2:0] CTRL_RST = 3'h3;
  // event bits of status and mask
  localparam int EV_INV = 0;
  localparam int EV_INEX = 1;
  localparam int EV_RI = 2;
  localparam int EV_CPU = 3;
  localparam logic [3:0] EV_RST = 4'h0;
  localparam logic [63:0] L_MAX = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] L_MIN = 64'h8000_0000_0000_0000;
  localparam logic [63:0] QNAN_NEW = 64'h7ff8_0000_0000_0000;
  localparam logic [63:0] QNAN_OLD = 64'h7ff7_ffff_ffff_ffff;
  localparam logic [10:0] S_TO_D = 11'h380;
  localparam logic [12:0] D_TOP = 13'h043e;
  localparam logic [12:0] S_DEN = 13'h0095;
  typedef enum logic [2:0] {
    EXC_NONE = 3'b000,
    EXC_CPU = 3'b001,
    EXC_RI = 3'b010,
    EXC_INV = 3'b011,
    EXC_INEX = 3'b100
  } fcu_exc_type;
  typedef struct packed {
    logic wrEn;
    logic [4:0] dest;
    logic [63:0] data;
  } fcu_res_type;
  typedef struct packed {
    logic valid;
    fcu_exc_type code;
  } fcu_trap_type;
endpackage : fcu_pkg

// ==== fcu_convert.sv ====
// fp format conversion unit: decode, convert, round, flags and traps
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module fcu_convert (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic issueValid,
  input wire logic [31:0] instrWord,
  input wire logic [63:0] srcA,
  input wire logic [63:0] srcB,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output fcu_pkg::fcu_res_type result,
  output fcu_pkg::fcu_trap_type trap,
  output logic irq
);
  logic [31:0] fpcsQ, fpcsD;
  logic [2:0] ctrlQ;
  logic [3:0] statQ, statD, maskQ, evt;
  logic [31:0] rdataQ;
  fcu_pkg::fcu_res_type resQ;
  fcu_pkg::fcu_trap_type trapQ;
  logic irqQ;
  logic [4:0] fmt;
  logic [5:0] fn;
  logic opOk, rtZero, isD, isL, isPack, isPl, isPu, legal, isPair;
  logic [1:0] rm;
  logic nanSel, r6;
  logic sgn, isMaxE, isZeroE, fz, snan;
  logic signed [12:0] eUn;
  logic [52:0] mant;
  logic [127:0] w;
  logic tiny, big, gL, sL, incL, ovf, invL, nanIn;
  logic [64:0] magL;
  logic [63:0] resL, defL;
  logic iSgn, gI, sI, incI;
  logic [63:0] iMag, norm;
  logic [6:0] lz;
  logic [12:0] adj, expB;
  logic [53:0] mI;
  logic [63:0] resI, resD;
  logic inv, inex, doConv, conv;
  logic [63:0] outData;
  logic [31:0] srcALo, srcBLo, srcAHi;

  // round increment for the four rounding modes
  function automatic logic rndInc(input logic [1:0] m, input logic s, input logic lsb,
                                  input logic g, input logic st);
    case (m)
      2'd0: rndInc = g & (st | lsb);
      2'd1: rndInc = 1'b0;
      2'd2: rndInc = ~s & (g | st);
      default: rndInc = s & (g | st);
    endcase
  endfunction : rndInc

  // leading zeros of a 64-bit magnitude
  function automatic logic [6:0] lzc(input logic [63:0] v);
    logic done;
    done = 1'b0;
    lzc = 7'd64;
    for (int i = 63; i >= 0; i--)
    begin
      if (!done && v[i])
      begin
        lzc = 7'(63 - i);
        done = 1'b1;
      end
    end
  endfunction : lzc

  assign rm = fpcsQ[fcu_pkg::RM_LO +: 2];
  assign nanSel = fpcsQ[fcu_pkg::NAN_SEL];
  // fpr_width_mode only decides whether long and pair results are defined; nothing reads it
  assign r6 = ctrlQ[fcu_pkg::CTL_R6];
  assign srcALo = srcA[31:0];
  assign srcAHi = srcA[63:32];
  assign srcBLo = srcB[31:0];

  // instruction decode
  assign fmt = instrWord[25:21];
  assign fn = instrWord[5:0];
  assign opOk = instrWord[31:26] == fcu_pkg::OP_FPU;
  assign rtZero = instrWord[20:16] == 5'h00;
  assign isD = opOk & rtZero & (fn == fcu_pkg::FN_TO_DBL);
  assign isL = opOk & rtZero & (fn == fcu_pkg::FN_TO_LONG);
  assign isPack = opOk & (fn == fcu_pkg::FN_PACK);
  assign isPl = opOk & rtZero & (fn == fcu_pkg::FN_PL);
  assign isPu = opOk & rtZero & (fn == fcu_pkg::FN_PU);
  // unknown operand_format or release 6 pair ops fall out as reserved
  assign legal = (isD & (fmt == fcu_pkg::FMT_S | fmt == fcu_pkg::FMT_W
                         | fmt == fcu_pkg::FMT_L))
               | (isL & (fmt == fcu_pkg::FMT_S | fmt == fcu_pkg::FMT_D))
               | (~r6 & isPack & fmt == fcu_pkg::FMT_S)
               | (~r6 & (isPl | isPu) & fmt == fcu_pkg::FMT_PAIR);
  assign isPair = isPack | isPl | isPu;

  // unpack a single or double source into sign, exponent and 53-bit mantissa
  always_comb
  begin
    if (fmt == fcu_pkg::FMT_S)
    begin
      sgn = srcA[31];
      isMaxE = &srcA[30:23];
      isZeroE = ~|srcA[30:23];
      fz = ~|srcA[22:0];
      snan = srcA[22] ^ nanSel;
      mant = {~isZeroE, srcA[22:0], 29'h0};
      eUn = isZeroE ? -13'sd126 : $signed({5'h0, srcA[30:23]}) - 13'sd127;
    end
    else
    begin
      sgn = srcA[63];
      isMaxE = &srcA[62:52];
      isZeroE = ~|srcA[62:52];
      fz = ~|srcA[51:0];
      snan = srcA[51] ^ nanSel;
      mant = {~isZeroE, srcA[51:0]};
      eUn = isZeroE ? -13'sd1022 : $signed({2'h0, srcA[62:52]}) - 13'sd1023;
    end
  end

  // float to long: align on a 64.64 grid, then round
  always_comb
  begin
    tiny = eUn < -13'sd1;
    big = eUn > 13'sd63; // -2^63 itself fits; ovf catches the rest of exponent 63
    if (!tiny && !big)
      w = (eUn == -13'sd1) ? ({63'h0, mant, 12'h0} >> 1)
                           : ({63'h0, mant, 12'h0} << eUn[5:0]);
    else
      w = 128'h0;
    gL = w[63];
    sL = (|w[62:0]) | (tiny & |mant);
    incL = rndInc(rm, sgn, w[64], gL, sL);
    magL = {1'b0, w[127:64]} + {64'h0, incL};
    ovf = big | (sgn ? (magL > {1'b0, fcu_pkg::L_MIN}) : (magL[64:63] != 2'b00));
    nanIn = isMaxE & ~fz;
    invL = isMaxE | ovf;
    resL = sgn ? 64'(-magL[63:0]) : magL[63:0];
    // legacy encoding saturates every invalid case to the largest positive value
    if (!nanSel)
      defL = fcu_pkg::L_MAX;
    else if (nanIn)
      defL = 64'h0;
    else
      defL = sgn ? fcu_pkg::L_MIN : fcu_pkg::L_MAX;
  end

  // integer to double, also used to normalise a denormal single
  always_comb
  begin
    if (fmt == fcu_pkg::FMT_W)
    begin
      iSgn = srcA[31];
      iMag = {32'h0, srcA[31] ? 32'(-srcA[31:0]) : srcA[31:0]};
      adj = 13'h0;
    end
    else if (fmt == fcu_pkg::FMT_L)
    begin
      iSgn = srcA[63];
      iMag = srcA[63] ? 64'(-srcA) : srcA;
      adj = 13'h0;
    end
    else
    begin
      iSgn = srcA[31];
      iMag = {41'h0, srcA[22:0]};
      adj = fcu_pkg::S_DEN;
    end
    lz = lzc(iMag);
    norm = iMag << lz[5:0];
    gI = norm[10];
    sI = |norm[9:0];
    incI = rndInc(rm, iSgn, norm[11], gI, sI);
    mI = {1'b0, norm[63:11]} + {53'h0, incI};
    expB = fcu_pkg::D_TOP - {6'h0, lz} - adj + {12'h0, mI[53]};
    resI = (iMag == 64'h0) ? 64'h0
         : {iSgn, expB[10:0], mI[53] ? 52'h0 : mI[51:0]};
  end

  // convert_to_double result and exception conditions per source
  always_comb
  begin
    resD = resI;
    inv = 1'b0;
    inex = 1'b0;
    if (isL)
    begin
      inv = invL;
      inex = ~invL & (gL | sL);
    end
    else if (fmt == fcu_pkg::FMT_L)
      inex = gI | sI;
    else if (fmt == fcu_pkg::FMT_S)
    begin
      // single and word sources never round, so inexact stays low
      if (isMaxE && !fz)
      begin
        resD = nanSel ? fcu_pkg::QNAN_NEW : fcu_pkg::QNAN_OLD;
        inv = snan;
      end
      else if (isMaxE || !isZeroE || fz)
        resD = {sgn, isMaxE ? 11'h7ff : (isZeroE ? 11'h0 : srcA[30:23] + fcu_pkg::S_TO_D),
                srcA[22:0], 29'h0};
    end
  end

  function automatic logic unitUsable();
    unitUsable = ctrlQ[fcu_pkg::CTL_USE];
  endfunction : unitUsable

  assign conv = issueValid & unitUsable() & legal & ~isPair;
  assign doConv = conv;

  // result data selected by operation
  always_comb
  begin
    if (isPack)
      outData = {srcALo, srcBLo};
    else if (isPl)
      outData = {32'h0, srcALo};
    else if (isPu)
      outData = {32'h0, srcAHi};
    else if (isL)
      outData = inv ? defL : resL;
    else
      outData = resD;
  end

  // result and trap, one cycle after issue
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      resQ <= '0;
      trapQ <= '0;
    end
    else
    begin
      resQ.wrEn <= 1'b0;
      resQ.dest <= instrWord[10:6];
      resQ.data <= outData;
      trapQ <= '0;
      if (issueValid)
      begin
        if (!ctrlQ[fcu_pkg::CTL_USE])
          trapQ <= '{1'b1, fcu_pkg::EXC_CPU};
        else if (!legal)
          trapQ <= '{1'b1, fcu_pkg::EXC_RI};
        else if (inv && fpcsQ[fcu_pkg::EN_INV])
          trapQ <= '{1'b1, fcu_pkg::EXC_INV};
        else if (inex && fpcsQ[fcu_pkg::EN_INEX])
          trapQ <= '{1'b1, fcu_pkg::EXC_INEX};
        else
          resQ.wrEn <= 1'b1;
      end
    end
  end

  // fp_control_status: bus write first, then the instruction's cause and flags
  always_comb
  begin
    fpcsD = (regWr && regAddr == fcu_pkg::ADDR_FPCS) ? regWdata : fpcsQ;
    if (doConv)
    begin
      fpcsD[fcu_pkg::CAU_HI:fcu_pkg::CAU_LO] = 6'h0;
      fpcsD[fcu_pkg::CAU_INV] = inv;
      fpcsD[fcu_pkg::CAU_INEX] = inex;
      fpcsD[fcu_pkg::FLG_INV] = fpcsD[fcu_pkg::FLG_INV] | inv;
      fpcsD[fcu_pkg::FLG_INEX] = fpcsD[fcu_pkg::FLG_INEX] | inex;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      fpcsQ <= fcu_pkg::FPCS_RST;
    else
      fpcsQ <= fpcsD;
  end

  // control and mask registers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrlQ <= fcu_pkg::CTRL_RST;
      maskQ <= fcu_pkg::EV_RST;
    end
    else if (regWr)
    begin
      if (regAddr == fcu_pkg::ADDR_CTRL)
        ctrlQ <= regWdata[2:0];
      if (regAddr == fcu_pkg::ADDR_MASK)
        maskQ <= regWdata[3:0];
    end
  end

  // sticky events; a new event beats a write-one-to-clear in the same cycle
  always_comb
  begin
    evt = 4'h0;
    evt[fcu_pkg::EV_CPU] = issueValid & ~ctrlQ[fcu_pkg::CTL_USE];
    evt[fcu_pkg::EV_RI] = issueValid & ctrlQ[fcu_pkg::CTL_USE] & ~legal;
    evt[fcu_pkg::EV_INV] = doConv & inv;
    evt[fcu_pkg::EV_INEX] = doConv & inex;
    statD = statQ;
    if (regWr && regAddr == fcu_pkg::ADDR_STAT)
      statD = statQ & ~regWdata[3:0];
    statD = statD | evt;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      statQ <= fcu_pkg::EV_RST;
      irqQ <= 1'b0;
    end
    else
    begin
      statQ <= statD;
      irqQ <= |(statD & maskQ);
    end
  end

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      rdataQ <= 32'h0;
    else if (regRd)
      case (regAddr)
        fcu_pkg::ADDR_FPCS: rdataQ <= fpcsQ;
        fcu_pkg::ADDR_CTRL: rdataQ <= {29'h0, ctrlQ};
        fcu_pkg::ADDR_STAT: rdataQ <= {28'h0, statQ};
        fcu_pkg::ADDR_MASK: rdataQ <= {28'h0, maskQ};
        default: rdataQ <= 32'h0;
      endcase
    else
      rdataQ <= 32'h0;
  end

  assign regRdata = rdataQ;
  assign result = resQ;
  assign trap = trapQ;
  assign irq = irqQ;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  logic okIssue;
  assign okIssue = issueValid & ctrlQ[fcu_pkg::CTL_USE] & legal;

  a_pack_halves: assert property (okIssue & isPack |=> result.wrEn
    && result.data == {$past(srcALo), $past(srcBLo)}) else $error("pack order");
  a_lower_copy: assert property (okIssue & isPl |=> result.wrEn
    && result.data[31:0] == $past(srcALo)) else $error("lower copy");
  a_upper_copy: assert property (okIssue & isPu |=> result.wrEn
    && result.data[31:0] == $past(srcAHi)) else $error("upper copy");
  a_pair_flags: assert property (okIssue & isPair & ~regWr |=>
    $stable(fpcsQ[17:2]) && !trap.valid) else $error("pair touched flags");
  a_inv_nowrite: assert property (okIssue & isL & invL & fpcsQ[fcu_pkg::EN_INV] |=>
    !result.wrEn && trap.code == fcu_pkg::EXC_INV) else $error("invalid wrote");
  a_default_old: assert property (okIssue & isL & invL & ~nanSel & ~fpcsQ[fcu_pkg::EN_INV]
    & ~regWr |=> result.data == fcu_pkg::L_MAX && fpcsQ[fcu_pkg::FLG_INV])
    else $error("legacy default");
  a_r6_reserved: assert property (issueValid & ctrlQ[fcu_pkg::CTL_USE] & r6 & isPair
    |=> trap.valid && trap.code == fcu_pkg::EXC_RI ##1 statQ[fcu_pkg::EV_RI])
    else $error("r6 pair not reserved");
  a_cpu_first: assert property (issueValid & ~ctrlQ[fcu_pkg::CTL_USE] |=>
    trap.code == fcu_pkg::EXC_CPU && !result.wrEn) else $error("cop unusable");
  a_exact_single: assert property (okIssue & isD & (fmt != fcu_pkg::FMT_L) & ~regWr
    |=> !fpcsQ[fcu_pkg::CAU_INEX]) else $error("inexact on exact");
endmodule : fcu_convert

// ==== fcu_pipe_model.sv ====
// pipeline model that issues one instruction with its operands per request
`timescale 1ns/1ns
module fcu_pipe_model (
  input wire logic clk_sys,
  input wire logic reqGo,
  input wire logic [31:0] reqInstr,
  input wire logic [63:0] reqA,
  input wire logic [63:0] reqB,
  output logic issueValid,
  output logic [31:0] instrWord,
  output logic [63:0] srcA,
  output logic [63:0] srcB
);
  initial
  begin
    issueValid = 1'b0;
    instrWord = 32'h0;
    srcA = 64'h0;
    srcB = 64'h0;
  end
  // operands invert each cycle between issues, so a sample one cycle late by the unit looks wrong
  always @(posedge clk_sys)
  begin
    issueValid <= reqGo;
    instrWord <= reqGo ? reqInstr : ~instrWord;
    srcA <= reqGo ? reqA : ~srcA;
    srcB <= reqGo ? reqB : ~srcB;
  end
endmodule : fcu_pipe_model

// ==== fp_format_conversion_unit_test.sv ====
// self-checking bench of the fp format conversion unit
`timescale 1ns/1ns
module fp_format_conversion_unit_test;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic reqGo = 1'b0;
  logic [31:0] reqInstr = 32'h0;
  logic [63:0] reqA = 64'h0;
  logic [63:0] reqB = 64'h0;
  logic issueValid;
  logic [31:0] instrWord;
  logic [63:0] srcA;
  logic [63:0] srcB;
  fcu_pkg::fcu_res_type result;
  fcu_pkg::fcu_trap_type trap;
  logic irq;
  fcu_pkg::fcu_res_type res;
  fcu_pkg::fcu_trap_type trp;
  logic [31:0] rv;
  int mismatches = 0;
  int compares = 0;
  // out-of-range, infinite and nan sources, with both default encodings
  localparam logic [63:0] BAD_SRC [6] = '{64'h7ff0_0000_0000_0000, 64'hfff0_0000_0000_0000,
    64'h7ff8_0000_0000_0000, 64'h4630_0000_0000_0000, 64'hc630_0000_0000_0000,
    64'h43e0_0000_0000_0000};
  localparam logic [63:0] BAD_NEW [6] = '{fcu_pkg::L_MAX, fcu_pkg::L_MIN, 64'h0,
    fcu_pkg::L_MAX, fcu_pkg::L_MIN, fcu_pkg::L_MAX};
  // 2.5 and -2.5 under each rounding mode: nearest, zero, plus, minus
  localparam logic [63:0] POS_RND [4] = '{64'h2, 64'h2, 64'h3, 64'h2};
  localparam logic [63:0] NEG_RND [4] = '{-64'sd2, -64'sd2, -64'sd2, -64'sd3};

  fcu_pipe_model pipe (.clk_sys(clk_sys), .reqGo(reqGo), .reqInstr(reqInstr), .reqA(reqA),
    .reqB(reqB), .issueValid(issueValid), .instrWord(instrWord), .srcA(srcA), .srcB(srcB));
  fcu_convert DUT (.clk_sys(clk_sys), .reset_n(reset_n), .issueValid(issueValid),
    .instrWord(instrWord), .srcA(srcA), .srcB(srcB), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .result(result), .trap(trap), .irq(irq));

  always #2 clk_sys = ~clk_sys;

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // watchdog: the whole run is a few hundred cycles
  initial
  begin
    #400000;
    mismatches++;
    test_done();
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    rv = regRdata;
  endtask : rd

  // answer stands exactly one cycle after the unit takes the issue
  task automatic issue(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
    @(posedge clk_sys);
    reqGo <= 1'b1;
    reqInstr <= ins;
    reqA <= a;
    reqB <= b;
    @(posedge clk_sys);
    reqGo <= 1'b0;
    @(posedge clk_sys);
    #1;
    res = result;
    trp = trap;
  endtask : issue

  task automatic wrote(input string what, input logic [31:0] ins, input logic [63:0] exp);
    chk({what, " wrEn"}, 64'h1, 64'(res.wrEn));
    chk({what, " trap"}, 64'h0, 64'(trp.valid));
    chk({what, " dest"}, 64'(ins[10:6]), 64'(res.dest));
    chk(what, exp, res.data);
  endtask : wrote

  task automatic trapped(input string what, input fcu_pkg::fcu_exc_type code);
    chk({what, " wrEn"}, 64'h0, 64'(res.wrEn));
    chk({what, " trap"}, 64'h1, 64'(trp.valid));
    chk({what, " code"}, 64'(code), 64'(trp.code));
  endtask : trapped

  function automatic logic [31:0] ins(input logic [4:0] fmt, input logic [5:0] fn);
    return {fcu_pkg::OP_FPU, fmt, 5'h0, 5'h0, 5'($urandom), fn};
  endfunction : ins

  function automatic logic [63:0] s2d(input logic [31:0] s);
    return {s[31], 11'({3'h0, s[30:23]} + 11'h380), s[22:0], 29'h0};
  endfunction : s2d

  function automatic logic [63:0] w2d(input logic [31:0] w);
    logic [63:0] m;
    int p;
    if (w == 32'h0)
      return 64'h0;
    m = {32'h0, w[31] ? (~w + 32'h1) : w};
    p = 31;
    while (m[p] == 1'b0)
      p--;
    m = m << (52 - p);
    return {w[31], 11'(1023 + p), m[51:0]};
  endfunction : w2d

  initial
  begin
    logic [31:0] i;
    logic [31:0] s;
    logic [63:0] a;
    logic [63:0] b;
    void'($urandom(69));
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    // reset values and an unmapped offset
    rd(fcu_pkg::ADDR_FPCS);
    chk("fpcs reset", 64'h0, 64'(rv));
    rd(fcu_pkg::ADDR_CTRL);
    chk("ctrl reset", 64'h3, 64'(rv));
    rd(fcu_pkg::ADDR_STAT);
    chk("status reset", 64'h0, 64'(rv));
    rd(fcu_pkg::ADDR_MASK);
    chk("mask reset", 64'h0, 64'(rv));
    rd(4'h6);
    chk("unmapped", 64'h0, 64'(rv));
    $display("test resets done");
    // pair moves keep cause and flags as they were
    wr(fcu_pkg::ADDR_FPCS, 32'h0001_0044);
    repeat (4)
    begin
      a = {$urandom, $urandom};
      b = {$urandom, $urandom};
      i = ins(fcu_pkg::FMT_S, fcu_pkg::FN_PACK);
      issue(i, a, b);
      wrote("pack", i, {a[31:0], b[31:0]});
      i = ins(fcu_pkg::FMT_PAIR, fcu_pkg::FN_PL);
      issue(i, a, b);
      wrote("lower", i, {32'h0, a[31:0]});
      i = ins(fcu_pkg::FMT_PAIR, fcu_pkg::FN_PU);
      issue(i, a, b);
      wrote("upper", i, {32'h0, a[63:32]});
    end
    rd(fcu_pkg::ADDR_FPCS);
    chk("fpcs after pair", 64'h0001_0044, 64'(rv));
    $display("test pairs done");
    // exact widening from single and word, with zero and extreme words among them
    wr(fcu_pkg::ADDR_FPCS, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      s = {1'($urandom), 8'($urandom_range(254, 1)), 23'($urandom)};
      i = ins(fcu_pkg::FMT_S, fcu_pkg::FN_TO_DBL);
      issue(i, 64'(s), 64'h0);
      wrote("single to double", i, s2d(s));
      s = (k == 0) ? 32'h0 : (k == 1) ? 32'h8000_0000 : $urandom;
      i = ins(fcu_pkg::FMT_W, fcu_pkg::FN_TO_DBL);
      issue(i, 64'(s), 64'h0);
      wrote("word to double", i, w2d(s));
      rd(fcu_pkg::ADDR_FPCS);
      chk("inexact cause", 64'h0, 64'(rv[fcu_pkg::CAU_INEX]));
    end
    // the smallest denormal single still widens exactly
    i = ins(fcu_pkg::FMT_S, fcu_pkg::FN_TO_DBL);
    issue(i, 64'h1, 64'h0);
    wrote("denormal single", i, 64'h36a0_0000_0000_0000);
    // long sources may round: 2^53+1 lies midway between two doubles
    i = ins(fcu_pkg::FMT_L, fcu_pkg::FN_TO_DBL);
    issue(i, 64'hffff_ffff_ffff_fffd, 64'h0);
    wrote("long to double", i, 64'hc008_0000_0000_0000);
    issue(i, 64'h0020_0000_0000_0001, 64'h0);
    wrote("long nearest", i, 64'h4340_0000_0000_0000);
    rd(fcu_pkg::ADDR_FPCS);
    chk("long inexact", 64'h1, 64'(rv[fcu_pkg::CAU_INEX]));
    wr(fcu_pkg::ADDR_FPCS, 32'h2);
    issue(i, 64'h0020_0000_0000_0001, 64'h0);
    wrote("long plus", i, 64'h4340_0000_0000_0001);
    wr(fcu_pkg::ADDR_FPCS, 32'h80);
    issue(i, 64'h0020_0000_0000_0001, 64'h0);
    trapped("inexact trap", fcu_pkg::EXC_INEX);
    $display("test widen done");
    // long conversion of halves under every rounding mode, double and single sources
    for (int m = 0; m < 4; m++)
    begin
      wr(fcu_pkg::ADDR_FPCS, 32'(m));
      i = ins(fcu_pkg::FMT_D, fcu_pkg::FN_TO_LONG);
      issue(i, 64'h4004_0000_0000_0000, 64'h0);
      wrote("round pos", i, POS_RND[m]);
      i = ins(fcu_pkg::FMT_S, fcu_pkg::FN_TO_LONG);
      issue(i, 64'hc020_0000, 64'h0);
      wrote("round neg", i, NEG_RND[m]);
    end
    i = ins(fcu_pkg::FMT_D, fcu_pkg::FN_TO_LONG);
    issue(i, 64'hc3e0_0000_0000_0000, 64'h0);
    wrote("long low edge", i, fcu_pkg::L_MIN);
    rd(fcu_pkg::ADDR_FPCS);
    chk("edge cause", 64'h0, 64'(rv[fcu_pkg::CAU_INV]));
    $display("test rounding done");
    // invalid sources under both default encodings, then with the enable set
    for (int n = 0; n < 2; n++)
      for (int k = 0; k < 6; k++)
      begin
        wr(fcu_pkg::ADDR_FPCS, 32'(n) << fcu_pkg::NAN_SEL);
        i = ins(fcu_pkg::FMT_D, fcu_pkg::FN_TO_LONG);
        issue(i, BAD_SRC[k], 64'h0);
        wrote("invalid default", i, (n == 0) ? fcu_pkg::L_MAX : BAD_NEW[k]);
        rd(fcu_pkg::ADDR_FPCS);
        chk("invalid flag", 64'h1, 64'(rv[fcu_pkg::FLG_INV]));
      end
    wr(fcu_pkg::ADDR_FPCS, 32'h800);
    issue(ins(fcu_pkg::FMT_D, fcu_pkg::FN_TO_LONG), BAD_SRC[1], 64'h0);
    trapped("invalid trap", fcu_pkg::EXC_INV);
    rd(fcu_pkg::ADDR_FPCS);
    chk("trap flag", 64'h1, 64'(rv[fcu_pkg::FLG_INV]));
    $display("test invalid done");
    // refused encodings, status, mask and the interrupt line
    wr(fcu_pkg::ADDR_FPCS, 32'h0);
    wr(fcu_pkg::ADDR_STAT, 32'hf);
    issue(ins(5'h12, fcu_pkg::FN_TO_DBL), 64'h0, 64'h0);
    trapped("bad format", fcu_pkg::EXC_RI);
    issue(ins(fcu_pkg::FMT_S, fcu_pkg::FN_TO_DBL) | 32'h0001_0000, 64'h0, 64'h0);
    trapped("nonzero field", fcu_pkg::EXC_RI);
    issue(ins(fcu_pkg::FMT_W, fcu_pkg::FN_TO_LONG), 64'h0, 64'h0);
    trapped("long from word", fcu_pkg::EXC_RI);
    rd(fcu_pkg::ADDR_STAT);
    chk("status reserved", 64'h4, 64'(rv));
    chk("irq masked", 64'h0, 64'(irq));
    wr(fcu_pkg::ADDR_MASK, 32'h4);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq raised", 64'h1, 64'(irq));
    wr(fcu_pkg::ADDR_STAT, 32'h4);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq cleared", 64'h0, 64'(irq));
    wr(fcu_pkg::ADDR_CTRL, 32'h1);
    issue(ins(fcu_pkg::FMT_S, fcu_pkg::FN_PACK), 64'h0, 64'h0);
    trapped("unusable", fcu_pkg::EXC_CPU);
    rd(fcu_pkg::ADDR_STAT);
    chk("status unusable", 64'h8, 64'(rv));
    wr(fcu_pkg::ADDR_CTRL, 32'h7);
    issue(ins(fcu_pkg::FMT_S, fcu_pkg::FN_PACK), 64'h0, 64'h0);
    trapped("release six pack", fcu_pkg::EXC_RI);
    issue(ins(fcu_pkg::FMT_PAIR, fcu_pkg::FN_PU), 64'h0, 64'h0);
    trapped("release six upper", fcu_pkg::EXC_RI);
    rd(fcu_pkg::ADDR_CTRL);
    chk("ctrl readback", 64'h7, 64'(rv));
    $display("test refusals done");
    test_done();
  end
endmodule : fp_format_conversion_unit_test
